// [ppic_edge.sv]
`timescale 1ns/1ns
`default_nettype none

// per-bit edge detector, polarity shared by the group
module ppic_edge #(
  parameter int W = 8
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] lvl, // synchronised levels
  input wire logic falling, // 0 rising, 1 falling
  output logic [W-1:0] hit // one-cycle edge pulse
);
  logic [W-1:0] prev;
  wire [W-1:0] rise = lvl & ~prev;
  wire [W-1:0] fall = ~lvl & prev;

  assign hit = falling ? fall : rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= '0;
    end else begin
      prev <= lvl;
    end
  end
endmodule : ppic_edge

`default_nettype wire

// [ppic_pins.sv]
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// external pins and cpu interrupt side
// ****************************************
module ppic_pins (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic p0_irq_req, // port zero request pulse
  output logic [7:0] p0_pin, // port zero pins
  output logic [7:0] p1_pin, // port one pins
  output logic [4:0] p2_pin, // port two pins
  output logic [7:0] p0_hits // count of port zero pulses
);
  initial begin
    p0_pin = 8'h00;
    p1_pin = 8'h00;
    p2_pin = 5'h00;
  end

  // levels held for many cycles, well above the two-cycle minimum
  task set_pins(input logic [7:0] v0, input logic [7:0] v1, input logic [4:0] v2);
    @(posedge pclk);
    p0_pin <= v0;
    p1_pin <= v1;
    p2_pin <= v2;
  endtask : set_pins

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_hits <= 8'h00;
    end else if (p0_irq_req) begin
      p0_hits <= p0_hits + 8'h01;
    end
  end
endmodule : ppic_pins

`default_nettype wire

// [ppic_pkg.sv]
// How it works
// - Eight port-one pending flags, one per pin, are set by a pin request and clear after reset.
// - Five port-two pending flags sit in the low bits and are set by a pin request.
// - Control bit 6 drives the output drive-strength select, 0 minimum drive and 1 maximum drive.
// - Control bit 5 enables interrupt requests from port-two inputs 4 to 0.
// - Control bit 4 enables interrupt requests from port-zero inputs 7 to 4.
// - Control bit 3 enables interrupt requests from port-zero inputs 3 to 0.
// - Control bit 2 selects the port-two request edge, 0 meaning a rising edge.
// - An edge-select bit of 1 makes a falling edge raise the request instead.
// - Control bits 1 and 0 select the request edge of port one and port zero.
// - A separate eight-bit mask enables each port-one pin interrupt.
`default_nettype none

package ppic_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_P1_FLAGS = 8'h8A;
  localparam logic [7:0] IDX_P2_FLAGS = 8'h8B;
  localparam logic [7:0] IDX_CTRL = 8'h8C;
  localparam logic [7:0] IDX_P1_MASK = 8'h8D;
  localparam logic [7:0] IDX_EVT_STATUS = 8'h90;
  localparam logic [7:0] IDX_EVT_MASK = 8'h91;
  // control field positions
  localparam int CTRL_DRIVE = 6;
  localparam int CTRL_P2_EN = 5;
  localparam int CTRL_P0H_EN = 4;
  localparam int CTRL_P0L_EN = 3;
  localparam int CTRL_P2_EDGE = 2;
  localparam int CTRL_P1_EDGE = 1;
  localparam int CTRL_P0_EDGE = 0;
  localparam logic [6:0] CTRL_WMASK = 7'h7F;
  // event status bit positions
  localparam int EVT_P0 = 0;
  localparam int EVT_P1 = 1;
  localparam int EVT_P2 = 2;
  localparam int EVT_W = 3;
  // reset values
  localparam logic [7:0] RST_P1_FLAGS = 8'h00;
  localparam logic [4:0] RST_P2_FLAGS = 5'h00;
  localparam logic [6:0] RST_CTRL = 7'h00;
  localparam logic [7:0] RST_P1_MASK = 8'h00;
  localparam logic [2:0] RST_EVT = 3'h0;
endpackage : ppic_pkg

`default_nettype wire

// [ppic_sync.sv]
`timescale 1ns/1ns
`default_nettype none

// two-stage synchroniser for asynchronous pin levels
module ppic_sync #(
  parameter int W = 8
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] d, // raw pin levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule : ppic_sync

`default_nettype wire

// [ppic_top.sv]
`timescale 1ns/1ns
`default_nettype none

module ppic_top #(
  parameter int P0_W = 8,
  parameter int P1_W = 8,
  parameter int P2_W = 5
) (
  input wire logic pclk, // system clock, 20 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire logic [P0_W-1:0] p0_pin, // port zero pins
  input wire logic [P1_W-1:0] p1_pin, // port one pins
  input wire logic [P2_W-1:0] p2_pin, // port two pins
  output logic drive_strength_select, // pad drive select
  output logic p0_irq_req, // port zero request pulse
  output logic p1_irq_req, // port one request level
  output logic p2_irq_req, // port two request level
  output logic irq // combined interrupt level
);

  // ****************************************
  // pin synchronisation and edge detection
  // ****************************************
  logic [P0_W-1:0] p0_sync;
  logic [P1_W-1:0] p1_sync;
  logic [P2_W-1:0] p2_sync;
  logic [P0_W-1:0] p0_hit;
  logic [P1_W-1:0] p1_hit;
  logic [P2_W-1:0] p2_hit;
  logic [6:0] port_interrupt_control;

  ppic_sync #(.W(P0_W)) u_sync0 (
    .pclk(pclk),
    .presetn(presetn),
    .d(p0_pin),
    .q(p0_sync)
  );

  ppic_sync #(.W(P1_W)) u_sync1 (
    .pclk(pclk),
    .presetn(presetn),
    .d(p1_pin),
    .q(p1_sync)
  );

  ppic_sync #(.W(P2_W)) u_sync2 (
    .pclk(pclk),
    .presetn(presetn),
    .d(p2_pin),
    .q(p2_sync)
  );

  ppic_edge #(.W(P0_W)) u_edge0 (
    .pclk(pclk),
    .presetn(presetn),
    .lvl(p0_sync),
    .falling(port_interrupt_control[ppic_pkg::CTRL_P0_EDGE]),
    .hit(p0_hit)
  );

  ppic_edge #(.W(P1_W)) u_edge1 (
    .pclk(pclk),
    .presetn(presetn),
    .lvl(p1_sync),
    .falling(port_interrupt_control[ppic_pkg::CTRL_P1_EDGE]),
    .hit(p1_hit)
  );

  ppic_edge #(.W(P2_W)) u_edge2 (
    .pclk(pclk),
    .presetn(presetn),
    .lvl(p2_sync),
    .falling(port_interrupt_control[ppic_pkg::CTRL_P2_EDGE]),
    .hit(p2_hit)
  );

  // ****************************************
  // apb decode
  // ****************************************
  function automatic logic is_idx(input logic [11:0] a, input logic [7:0] idx);
    is_idx = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction : is_idx

  wire wr = psel && penable && pwrite;
  wire sel_p1f = is_idx(paddr, ppic_pkg::IDX_P1_FLAGS);
  wire sel_p2f = is_idx(paddr, ppic_pkg::IDX_P2_FLAGS);
  wire sel_ctrl = is_idx(paddr, ppic_pkg::IDX_CTRL);
  wire sel_p1m = is_idx(paddr, ppic_pkg::IDX_P1_MASK);
  wire sel_evs = is_idx(paddr, ppic_pkg::IDX_EVT_STATUS);
  wire sel_evm = is_idx(paddr, ppic_pkg::IDX_EVT_MASK);
  wire mapped = sel_p1f | sel_p2f | sel_ctrl | sel_p1m | sel_evs | sel_evm;
  wire wr_p1f = wr && sel_p1f;
  wire wr_p2f = wr && sel_p2f;
  wire wr_ctrl = wr && sel_ctrl;
  wire wr_p1m = wr && sel_p1m;
  wire wr_evs = wr && sel_evs;
  wire wr_evm = wr && sel_evm;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ****************************************
  // control and mask registers
  // ****************************************
  logic [7:0] port_one_pin_mask;
  logic [2:0] evt_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_interrupt_control <= ppic_pkg::RST_CTRL;
      port_one_pin_mask <= ppic_pkg::RST_P1_MASK;
      evt_mask <= ppic_pkg::RST_EVT;
    end else begin
      if (wr_ctrl) begin
        port_interrupt_control <= pwdata[6:0] & ppic_pkg::CTRL_WMASK;
      end
      if (wr_p1m) begin
        port_one_pin_mask <= pwdata[7:0];
      end
      if (wr_evm) begin
        evt_mask <= pwdata[2:0];
      end
    end
  end

  assign drive_strength_select = port_interrupt_control[ppic_pkg::CTRL_DRIVE];

  // ****************************************
  // pending flags
  // ****************************************
  logic [7:0] port_one_pending_flags;
  logic [4:0] port_two_pending_flags;
  wire [7:0] p1_keep = wr_p1f ? pwdata[7:0] : 8'hFF;
  wire [4:0] p2_keep = wr_p2f ? pwdata[4:0] : 5'h1F;
  // a pin edge in the clearing cycle wins
  wire [7:0] next_p1_flags = (port_one_pending_flags & p1_keep) | p1_hit;
  wire [4:0] next_p2_flags = (port_two_pending_flags & p2_keep) | p2_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_one_pending_flags <= ppic_pkg::RST_P1_FLAGS;
      port_two_pending_flags <= ppic_pkg::RST_P2_FLAGS;
    end else begin
      port_one_pending_flags <= next_p1_flags;
      port_two_pending_flags <= next_p2_flags;
    end
  end

  // ****************************************
  // requests towards the cpu
  // ****************************************
  wire p0_lo_go = port_interrupt_control[ppic_pkg::CTRL_P0L_EN] && (|p0_hit[3:0]);
  wire p0_hi_go = port_interrupt_control[ppic_pkg::CTRL_P0H_EN] && (|p0_hit[7:4]);
  wire p1_go = |(port_one_pending_flags & port_one_pin_mask);
  wire p2_go = port_interrupt_control[ppic_pkg::CTRL_P2_EN] && (|port_two_pending_flags);
  logic p1_go_d;
  logic p2_go_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_irq_req <= 1'b0;
      p1_irq_req <= 1'b0;
      p2_irq_req <= 1'b0;
      p1_go_d <= 1'b0;
      p2_go_d <= 1'b0;
    end else begin
      p0_irq_req <= p0_lo_go || p0_hi_go;
      p1_irq_req <= p1_go;
      p2_irq_req <= p2_go;
      p1_go_d <= p1_go;
      p2_go_d <= p2_go;
    end
  end

  // ****************************************
  // interrupt status, mask and output
  // ****************************************
  logic [2:0] evt_status;
  wire [2:0] evt_set = {p2_go && !p2_go_d, p1_go && !p1_go_d, p0_lo_go || p0_hi_go};
  wire [2:0] evt_clr = wr_evs ? pwdata[2:0] : 3'h0;
  wire [2:0] next_evt = (evt_status & ~evt_clr) | evt_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= ppic_pkg::RST_EVT;
      irq <= 1'b0;
    end else begin
      evt_status <= next_evt;
      irq <= |(next_evt & evt_mask);
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  wire [7:0] rd_byte =
    sel_p1f ? port_one_pending_flags :
    sel_p2f ? {3'h0, port_two_pending_flags} :
    sel_ctrl ? {1'b0, port_interrupt_control} :
    sel_p1m ? port_one_pin_mask :
    sel_evs ? {5'h00, evt_status} :
    sel_evm ? {5'h00, evt_mask} : 8'h00;

  assign prdata = {24'h000000, rd_byte};

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_p2_rise;
    !p2_sync[0] ##1 p2_sync[0] && !port_interrupt_control[ppic_pkg::CTRL_P2_EDGE];
  endsequence

  sequence s_p1_fall;
    p1_sync[0] ##1 !p1_sync[0] && port_interrupt_control[ppic_pkg::CTRL_P1_EDGE];
  endsequence

  sequence s_p1_rise;
    !p1_sync[6] ##1 p1_sync[6] && !port_interrupt_control[ppic_pkg::CTRL_P1_EDGE];
  endsequence

  sequence s_p0_fall;
    p0_sync[5] ##1 !p0_sync[5] && port_interrupt_control[ppic_pkg::CTRL_P0_EDGE];
  endsequence

  AST_P1_SET: assert property (
    p1_hit[3] |=> port_one_pending_flags[3])
    else $error("port one flag not set by edge");

  AST_P2_RISE: assert property (
    s_p2_rise |=> port_two_pending_flags[0])
    else $error("port two rising edge missed");

  AST_P1_FALL: assert property (
    s_p1_fall |=> port_one_pending_flags[0])
    else $error("port one falling edge missed");

  AST_P1_CLR: assert property (
    wr_p1f && !pwdata[2] && !p1_hit[2] |=> !port_one_pending_flags[2])
    else $error("write of zero did not clear flag");

  AST_P1_KEEP: assert property (
    wr_p1f && pwdata[5] && port_one_pending_flags[5] |=> port_one_pending_flags[5])
    else $error("write of one disturbed flag");

  AST_P2_UPPER: assert property (
    sel_p2f |-> prdata[7:5] == 3'b000)
    else $error("unused port two bits not zero");

  AST_DRIVE: assert property (
    wr_ctrl |=> drive_strength_select == $past(pwdata[6]))
    else $error("drive select not following control");

  AST_P2_GATE: assert property (
    !port_interrupt_control[ppic_pkg::CTRL_P2_EN] |=> !p2_irq_req)
    else $error("port two request while disabled");

  AST_P0_HI: assert property (
    port_interrupt_control[ppic_pkg::CTRL_P0H_EN] && !port_interrupt_control[ppic_pkg::CTRL_P0L_EN]
      && (|p0_hit[7:4]) |=> p0_irq_req)
    else $error("port zero upper request lost");

  AST_P0_LO: assert property (
    !port_interrupt_control[ppic_pkg::CTRL_P0L_EN] && !port_interrupt_control[ppic_pkg::CTRL_P0H_EN]
      |=> !p0_irq_req)
    else $error("port zero request while disabled");

  AST_P0_EDGE: assert property (
    port_interrupt_control[ppic_pkg::CTRL_P0_EDGE] && $rose(p0_sync[1]) |-> !p0_hit[1])
    else $error("port zero edge select ignored");

  AST_P1_MASK: assert property (
    (port_one_pending_flags & port_one_pin_mask) == 8'h00 |=> !p1_irq_req)
    else $error("masked port one pin raised request");

  AST_P2_SET: assert property (
    p2_hit[4] |=> port_two_pending_flags[4])
    else $error("port two flag not set by edge");

  AST_P2_CLR: assert property (
    wr_p2f && !pwdata[1] && !p2_hit[1] |=> !port_two_pending_flags[1])
    else $error("write of zero did not clear port two flag");

  AST_P1_HOLD: assert property (
    !wr_p1f |=> (port_one_pending_flags & $past(port_one_pending_flags)) == $past(port_one_pending_flags))
    else $error("port one flag dropped without a write");

  AST_DRIVE_HOLD: assert property (
    !wr_ctrl |=> $stable(drive_strength_select))
    else $error("drive select changed without a write");

  AST_P2_REQ: assert property (
    port_interrupt_control[ppic_pkg::CTRL_P2_EN] && (port_two_pending_flags != 5'h00) |=> p2_irq_req)
    else $error("enabled port two request missing");

  AST_P1_REQ: assert property (
    (port_one_pending_flags & port_one_pin_mask) != 8'h00 |=> p1_irq_req)
    else $error("unmasked port one request missing");

  AST_P0_LO_GO: assert property (
    port_interrupt_control[ppic_pkg::CTRL_P0L_EN] && (|p0_hit[3:0]) |=> p0_irq_req)
    else $error("port zero lower request lost");

  AST_P0_HI_OFF: assert property (
    !port_interrupt_control[ppic_pkg::CTRL_P0H_EN] && (p0_hit[3:0] == 4'h0) |=> !p0_irq_req)
    else $error("port zero upper request while disabled");

  AST_P0_LO_OFF: assert property (
    !port_interrupt_control[ppic_pkg::CTRL_P0L_EN] && (p0_hit[7:4] == 4'h0) |=> !p0_irq_req)
    else $error("port zero lower request while disabled");

  AST_P1_EDGE_SEL: assert property (
    port_interrupt_control[ppic_pkg::CTRL_P1_EDGE] && $rose(p1_sync[2]) |-> !p1_hit[2])
    else $error("port one edge select ignored");

  AST_P2_RISE_SEL: assert property (
    !port_interrupt_control[ppic_pkg::CTRL_P2_EDGE] && $fell(p2_sync[3]) |-> !p2_hit[3])
    else $error("port two falling edge taken while rising selected");

  AST_P0_FALL: assert property (
    s_p0_fall |-> p0_hit[5])
    else $error("port zero falling edge missed");

  AST_P1_RISE: assert property (
    s_p1_rise |-> p1_hit[6])
    else $error("port one rising edge missed");

  AST_P2_FALL: assert property (
    port_interrupt_control[ppic_pkg::CTRL_P2_EDGE] && $fell(p2_sync[2]) |-> p2_hit[2])
    else $error("port two falling edge missed");

  AST_IRQ_SET: assert property (
    (evt_status & evt_mask) != 3'h0 && !wr_evs && !wr_evm |=> irq)
    else $error("interrupt low with unmasked status");

  AST_IRQ_CLR: assert property (
    (next_evt & evt_mask) == 3'h0 |=> !irq)
    else $error("interrupt high with no unmasked status");

  AST_EVT_STICKY: assert property (
    evt_status[1] && !wr_evs |=> evt_status[1])
    else $error("event status bit dropped without a write");

endmodule : ppic_top

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  localparam logic [11:0] A_P1F = {2'h0, ppic_pkg::IDX_P1_FLAGS, 2'h0};
  localparam logic [11:0] A_P2F = {2'h0, ppic_pkg::IDX_P2_FLAGS, 2'h0};
  localparam logic [11:0] A_CTL = {2'h0, ppic_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_MSK = {2'h0, ppic_pkg::IDX_P1_MASK, 2'h0};
  localparam logic [11:0] A_EST = {2'h0, ppic_pkg::IDX_EVT_STATUS, 2'h0};
  localparam logic [11:0] A_EMK = {2'h0, ppic_pkg::IDX_EVT_MASK, 2'h0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic drive_strength_select, p0_irq_req, p1_irq_req, p2_irq_req, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [7:0] p0_pin, p1_pin, p0_hits;
  logic [4:0] p2_pin;
  int failures, compares;

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  ppic_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p0_pin(p0_pin), .p1_pin(p1_pin), .p2_pin(p2_pin), .drive_strength_select(drive_strength_select),
    .p0_irq_req(p0_irq_req), .p1_irq_req(p1_irq_req), .p2_irq_req(p2_irq_req), .irq(irq));

  ppic_pins pins (.pclk(pclk), .presetn(presetn), .p0_irq_req(p0_irq_req), .p0_pin(p0_pin),
    .p1_pin(p1_pin), .p2_pin(p2_pin), .p0_hits(p0_hits));

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task give_verdict;
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk_val(name, exp, rdata);
  endtask : rd

  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    failures = 0;
    compares = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd("p1_flags", A_P1F, 32'h0000_0000);
    rd("p2_flags", A_P2F, 32'h0000_0000);
    rd("ctrl", A_CTL, 32'h0000_0000);
    rd("p1_mask", A_MSK, 32'h0000_0000);
    chk_bit("drive", 1'b0, drive_strength_select);
    wr(A_CTL, 32'h0000_00FF);
    rd("ctrl", A_CTL, 32'h0000_007F);
    chk_bit("drive", 1'b1, drive_strength_select);
    wr(A_CTL, 32'h0000_0000);
    idle(1);
    chk_bit("drive", 1'b0, drive_strength_select);
    // port one rising, masked then unmasked, then falling
    pins.set_pins(8'h00, 8'hFF, 5'h00);
    idle(5);
    rd("p1_flags", A_P1F, 32'h0000_00FF);
    chk_bit("p1_req", 1'b0, p1_irq_req);
    wr(A_MSK, 32'h0000_0001);
    idle(2);
    chk_bit("p1_req", 1'b1, p1_irq_req);
    wr(A_P1F, 32'h0000_00FE);
    rd("p1_flags", A_P1F, 32'h0000_00FE);
    chk_bit("p1_req", 1'b0, p1_irq_req);
    wr(A_P1F, 32'h0000_0000);
    rd("p1_flags", A_P1F, 32'h0000_0000);
    wr(A_CTL, 32'h0000_0002);
    pins.set_pins(8'h00, 8'h00, 5'h00);
    idle(5);
    rd("p1_flags", A_P1F, 32'h0000_00FF);
    wr(A_P1F, 32'h0000_0000);
    // port two gating and edge choice
    wr(A_CTL, 32'h0000_0000);
    pins.set_pins(8'h00, 8'h00, 5'h1F);
    idle(5);
    rd("p2_flags", A_P2F, 32'h0000_001F);
    chk_bit("p2_req", 1'b0, p2_irq_req);
    wr(A_CTL, 32'h0000_0020);
    idle(2);
    chk_bit("p2_req", 1'b1, p2_irq_req);
    wr(A_P2F, 32'h0000_0000);
    pins.set_pins(8'h00, 8'h00, 5'h00);
    idle(5);
    rd("p2_flags", A_P2F, 32'h0000_0000);
    wr(A_CTL, 32'h0000_0004);
    pins.set_pins(8'h00, 8'h00, 5'h1F);
    idle(5);
    rd("p2_flags", A_P2F, 32'h0000_0000);
    pins.set_pins(8'h00, 8'h00, 5'h00);
    idle(5);
    rd("p2_flags", A_P2F, 32'h0000_001F);
    wr(A_P2F, 32'h0000_0000);
    // port zero halves
    wr(A_CTL, 32'h0000_0008);
    pins.set_pins(8'h10, 8'h00, 5'h00);
    idle(5);
    chk_val("p0_hits", 32'h0000_0000, {24'h0, p0_hits});
    pins.set_pins(8'h11, 8'h00, 5'h00);
    idle(5);
    chk_val("p0_hits", 32'h0000_0001, {24'h0, p0_hits});
    wr(A_CTL, 32'h0000_0011);
    pins.set_pins(8'h01, 8'h00, 5'h00);
    idle(5);
    chk_val("p0_hits", 32'h0000_0002, {24'h0, p0_hits});
    pins.set_pins(8'h00, 8'h00, 5'h00);
    idle(5);
    chk_val("p0_hits", 32'h0000_0002, {24'h0, p0_hits});
    // event status, mask and clear
    rd("evt_status", A_EST, 32'h0000_0007);
    chk_bit("irq", 1'b0, irq);
    wr(A_EMK, 32'h0000_0001);
    idle(2);
    chk_bit("irq", 1'b1, irq);
    wr(A_EST, 32'h0000_0001);
    idle(2);
    chk_bit("irq", 1'b0, irq);
    rd("evt_status", A_EST, 32'h0000_0006);
    // unmapped address
    xfer(1'b0, 12'h3FC, 32'h0000_0000);
    chk_bit("pslverr", 1'b1, err);
    chk_val("unmapped_data", 32'h0000_0000, rdata);
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    give_verdict;
  end
endmodule : tb_top

`default_nettype wire
